// ---- rtl/pktbuf_map.svh ----
// Register offsets, field positions, reset values and constants.
// Operation
// - Transmit and receive data share one buffer, each from its own base.
// - After reset the receive base is 0x00 and the transmit base 0x80.
// - Either base may be set anywhere in the 256 byte buffer.
// - Entering sleep clears the buffer; no buffer access while asleep.
// - Outside sleep the buffer keeps its bytes until overwritten.
// - Data port accesses use the access pointer, which then increments.
// - Transmit length gives the number of payload bytes sent.
// - Explicit header sets the received byte count; implicit leaves it.
// - Last packet start records where the newest received packet begins.
// - Received bytes are stored even when the payload check fails.
// - Long receptions run on past their region into transmit data.
// - Sleep allows only registers; modem select changes only in sleep.
// - Standby powers oscillator and baseband only.
// - Synthesis modes lock the matching PLL with the RF section off.
// - Transmit sends one packet, flags completion, returns to standby.
// - Continuous receive keeps receiving until the host changes mode.
// - Single receive ends after one packet and returns to standby.
// - Any mode may be written directly from any other mode.
// - Carrier frequency equals the 24-bit word times crystal over 2^19.
// - All buffer, configuration and status access goes via the slave port.
`ifndef PKTBUF_MAP_SVH
`define PKTBUF_MAP_SVH
`define OFS_DATA      8'h00
`define OFS_PTR       8'h04
`define OFS_TX_BASE   8'h08
`define OFS_RX_BASE   8'h0C
`define OFS_LAST      8'h10
`define OFS_RX_COUNT  8'h14
`define OFS_TX_LEN    8'h18
`define OFS_OPMODE    8'h1C
`define OFS_FREQ      8'h20
`define OFS_FLAGS     8'h24
`define OFS_CONFIG    8'h28
`define OPM_SEL_BIT   7
`define FLG_TX_BIT    0
`define FLG_RX_BIT    1
`define FLG_CRC_BIT   2
`define CFG_IMPL_BIT  0
`define RX_BASE_RST   8'h00
`define TX_BASE_RST   8'h80
`define TX_LEN_RST    8'h01
`define FREQ_RST      24'h6C8000
`define XOSC_HZ       64'd32000000
`define FSTEP_SHIFT   19
`define BUF_LAST      8'hFF
`endif

// ---- rtl/pktbuf_pkg.sv ----
// Types shared by the packet buffer and mode control block.
package pktbuf_pkg;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STBY  = 3'h1,
    MODE_TX_SYNTH_MODE  = 3'h2,
    MODE_TX    = 3'h3,
    MODE_RX_SYNTH_MODE  = 3'h4,
    MODE_RXC   = 3'h5,
    MODE_RXS   = 3'h6,
    MODE_CAD   = 3'h7
  } mode_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_SEND = 3'b010,
    T_END  = 3'b100
  } tx_state_t;
  typedef struct packed {
    logic osc;
    logic baseband;
    logic pll_tx;
    logic pll_rx;
    logic rf_tx;
    logic rf_rx;
    logic pa_ramp;
  } power_t;
  typedef struct packed {
    logic crc_err;
    logic rx_done;
    logic tx_done;
  } flags_t;
endpackage : pktbuf_pkg

// ---- rtl/packet_buffer_mode_control.sv ----
// Packet buffer with mode control, reached over an AHB-Lite slave.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`include "pktbuf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_mode_control (
  input  wire logic           core_clk,        // System clock, 50 MHz.
  input  wire logic           rst,             // Asynchronous reset.
  input  wire logic           hsel,            // Slave select.
  input  wire logic [31:0]    haddr,           // Byte address.
  input  wire logic [1:0]     htrans,          // Transfer type.
  input  wire logic           hwrite,          // Write when high.
  input  wire logic [2:0]     hsize,           // Word only.
  input  wire logic [31:0]    hwdata,          // Write data.
  input  wire logic           hready,          // Bus ready.
  output logic      [31:0]    hrdata,          // Read data.
  output logic                hreadyout,       // Slave ready.
  output logic                hresp,           // Always OKAY.
  input  wire logic           link_clk,        // Modem bit clock.
  input  wire logic           link_rx_frame,   // Receive packet frame.
  input  wire logic           link_rx_data,    // Receive bit.
  input  wire logic           link_rx_crc_err, // Payload check failed.
  output logic                link_tx_frame,   // Transmit packet frame.
  output logic                link_tx_data,    // Transmit bit.
  output pktbuf_pkg::power_t  power,           // Block power enables.
  output logic      [31:0]    carrier_hz       // Carrier frequency in Hz.
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [31:0] freq_hz(input logic [23:0] w);
    logic [63:0] p;
    p = {40'h0, w} * `XOSC_HZ;
    freq_hz = p[`FSTEP_SHIFT+31:`FSTEP_SHIFT];
  endfunction : freq_hz

  function automatic pktbuf_pkg::power_t pwr_of(input pktbuf_pkg::mode_t m);
    pktbuf_pkg::power_t p;
    p = '0;
    p.osc = (m != pktbuf_pkg::MODE_SLEEP);
    p.baseband = (m != pktbuf_pkg::MODE_SLEEP);
    p.pll_tx = (m == pktbuf_pkg::MODE_TX_SYNTH_MODE) || (m == pktbuf_pkg::MODE_TX);
    p.pll_rx = (m == pktbuf_pkg::MODE_RX_SYNTH_MODE) || (m == pktbuf_pkg::MODE_RXC)
            || (m == pktbuf_pkg::MODE_RXS) || (m == pktbuf_pkg::MODE_CAD);
    p.rf_tx = (m == pktbuf_pkg::MODE_TX);
    p.pa_ramp = (m == pktbuf_pkg::MODE_TX);
    p.rf_rx = (m == pktbuf_pkg::MODE_RXC) || (m == pktbuf_pkg::MODE_RXS)
           || (m == pktbuf_pkg::MODE_CAD);
    pwr_of = p;
  endfunction : pwr_of

  ////////////////////////////////////////////////////////////////////////////
  logic                  ap_wr_q;
  logic                  ap_rd_q;
  logic [7:0]            ap_addr_q;
  logic                  wr_fire;
  logic                  rd_fire;
  logic [31:0]           rd_val;
  logic [7:0]            mem [0:255];
  logic [7:0]            ptr_q;
  logic [7:0]            tx_base_q;
  logic [7:0]            rx_base_q;
  logic [7:0]            tx_len_q;
  logic                  implicit_q;
  logic [23:0]           freq_q;
  pktbuf_pkg::mode_t     mode_q;
  pktbuf_pkg::mode_t     mode_prev_q;
  logic                  modem_sel_q;
  pktbuf_pkg::flags_t    flags_q;
  logic                  clr_busy_q;
  logic [7:0]            clr_idx_q;
  logic [3:0]            s1_q;
  logic [3:0]            s2_q;
  logic                  clk_d_q;
  logic                  frm_d_q;
  logic [7:0]            rx_wr_pos_q;
  logic [7:0]            last_start_q;
  logic [7:0]            rx_count_q;
  logic [2:0]            rx_bits_q;
  logic [7:0]            rx_sh_q;
  logic                  rx_hdr_q;
  logic                  rx_act_q;
  pktbuf_pkg::tx_state_t tx_st_q;
  logic [7:0]            tx_ptr_q;
  logic [7:0]            tx_left_q;
  logic [2:0]            tx_bit_q;
  logic [7:0]            tx_sh_q;

  // AHB-Lite slave: writes complete with no wait state, reads take one.
  wire acc = hsel && htrans[1] && hready;
  assign wr_fire = ap_wr_q && hreadyout;
  assign rd_fire = ap_rd_q && !hreadyout;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_wr_q   <= acc && hwrite;
      ap_rd_q   <= acc && !hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (acc && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (!hreadyout) begin
      hreadyout <= 1'b1;
      hrdata    <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire sleep      = (mode_q == pktbuf_pkg::MODE_SLEEP);
  wire buf_ok     = !sleep && !clr_busy_q;
  wire host_dwr   = wr_fire && hit(ap_addr_q, `OFS_DATA) && buf_ok;
  wire host_drd   = rd_fire && hit(ap_addr_q, `OFS_DATA) && buf_ok;
  wire mode_wr    = wr_fire && hit(ap_addr_q, `OFS_OPMODE);
  wire rx_mode    = (mode_q == pktbuf_pkg::MODE_RXC)
                 || (mode_q == pktbuf_pkg::MODE_RXS);
  wire rx_prev    = (mode_prev_q == pktbuf_pkg::MODE_RXC)
                 || (mode_prev_q == pktbuf_pkg::MODE_RXS);
  wire sleep_in   = sleep && (mode_prev_q != pktbuf_pkg::MODE_SLEEP);
  wire tx_start   = (mode_q == pktbuf_pkg::MODE_TX)
                 && (mode_prev_q != pktbuf_pkg::MODE_TX);
  wire tx_end     = (tx_st_q == pktbuf_pkg::T_END);
  wire clk_rise   = s2_q[0] && !clk_d_q;
  wire clk_fall   = !s2_q[0] && clk_d_q;
  wire frm_rise   = s2_q[1] && !frm_d_q;
  wire frm_fall   = !s2_q[1] && frm_d_q;
  wire [7:0] rx_byte = {rx_sh_q[6:0], s2_q[2]};
  wire rx_bit_ok  = rx_act_q && rx_mode && !frm_fall && clk_rise;
  wire rx_wr_en   = rx_bit_ok && (rx_bits_q == 3'h7) && !rx_hdr_q;
  wire rx_end     = rx_act_q && rx_mode && frm_fall;

  // Sleep reads the buffer as zero so stale or cleared data never leaks.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (ap_addr_q)
      `OFS_DATA:     rd_val[7:0] = buf_ok ? mem[ptr_q] : 8'h00;
      `OFS_PTR:      rd_val[7:0] = ptr_q;
      `OFS_TX_BASE:  rd_val[7:0] = tx_base_q;
      `OFS_RX_BASE:  rd_val[7:0] = rx_base_q;
      `OFS_LAST:     rd_val[7:0] = last_start_q;
      `OFS_RX_COUNT: rd_val[7:0] = rx_count_q;
      `OFS_TX_LEN:   rd_val[7:0] = tx_len_q;
      `OFS_OPMODE:   rd_val[7:0] = {modem_sel_q, 4'h0, mode_q};
      `OFS_FREQ:     rd_val[23:0] = freq_q;
      `OFS_FLAGS:    rd_val[2:0] = flags_q;
      `OFS_CONFIG:   rd_val[0] = implicit_q;
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration is accepted in every mode; the host keeps to safe modes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_base_q  <= `TX_BASE_RST;
      rx_base_q  <= `RX_BASE_RST;
      tx_len_q   <= `TX_LEN_RST;
      implicit_q <= 1'b0;
      freq_q     <= `FREQ_RST;
    end else if (wr_fire) begin
      if (hit(ap_addr_q, `OFS_TX_BASE)) tx_base_q <= hwdata[7:0];
      if (hit(ap_addr_q, `OFS_RX_BASE)) rx_base_q <= hwdata[7:0];
      if (hit(ap_addr_q, `OFS_TX_LEN)) tx_len_q <= hwdata[7:0];
      if (hit(ap_addr_q, `OFS_CONFIG)) implicit_q <= hwdata[`CFG_IMPL_BIT];
      if (hit(ap_addr_q, `OFS_FREQ)) freq_q <= hwdata[23:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      carrier_hz <= 32'h0000_0000;
    end else begin
      carrier_hz <= freq_hz(freq_q);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= 8'h00;
    end else if (wr_fire && hit(ap_addr_q, `OFS_PTR)) begin
      ptr_q <= hwdata[7:0];
    end else if (host_dwr || host_drd) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A host write always wins over the automatic return to standby.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q      <= pktbuf_pkg::MODE_SLEEP;
      mode_prev_q <= pktbuf_pkg::MODE_SLEEP;
      modem_sel_q <= 1'b0;
    end else begin
      mode_prev_q <= mode_q;
      if (mode_wr) begin
        mode_q <= pktbuf_pkg::mode_t'(hwdata[2:0]);
        if (sleep) modem_sel_q <= hwdata[`OPM_SEL_BIT];
      end else if (tx_end) begin
        mode_q <= pktbuf_pkg::MODE_STBY;
      end else if (rx_end && mode_q == pktbuf_pkg::MODE_RXS) begin
        mode_q <= pktbuf_pkg::MODE_STBY;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power <= '0;
    end else begin
      power <= pwr_of(mode_q);
    end
  end

  // Flags are write-one-to-clear; a new event in the same cycle wins.
  wire flg_wr = wr_fire && hit(ap_addr_q, `OFS_FLAGS);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q.tx_done <= tx_end
        || (flags_q.tx_done && !(flg_wr && hwdata[`FLG_TX_BIT]));
      flags_q.rx_done <= rx_end
        || (flags_q.rx_done && !(flg_wr && hwdata[`FLG_RX_BIT]));
      flags_q.crc_err <= (rx_end && s2_q[3])
        || (flags_q.crc_err && !(flg_wr && hwdata[`FLG_CRC_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clearing walks one byte per cycle, so it lasts 256 cycles after reset
  // or after entering sleep; buffer access is ignored until it finishes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clr_busy_q <= 1'b1;
      clr_idx_q  <= 8'h00;
    end else if (sleep_in) begin
      clr_busy_q <= 1'b1;
      clr_idx_q  <= 8'h00;
    end else if (clr_busy_q) begin
      clr_idx_q <= clr_idx_q + 8'h01;
      if (clr_idx_q == `BUF_LAST) clr_busy_q <= 1'b0;
    end
  end

  // Both ports may write in one cycle; the receive side wins a collision.
  always_ff @(posedge core_clk) begin
    if (clr_busy_q) begin
      mem[clr_idx_q] <= 8'h00;
    end else begin
      if (host_dwr) mem[ptr_q] <= hwdata[7:0];
      if (rx_wr_en) mem[rx_wr_pos_q] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link inputs come from another clock and pass two flip-flops first.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q    <= 4'h0;
      s2_q    <= 4'h0;
      clk_d_q <= 1'b0;
      frm_d_q <= 1'b0;
    end else begin
      s1_q    <= {link_rx_crc_err, link_rx_data, link_rx_frame, link_clk};
      s2_q    <= s1_q;
      clk_d_q <= s2_q[0];
      frm_d_q <= s2_q[1];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_wr_pos_q  <= 8'h00;
      last_start_q <= 8'h00;
      rx_count_q   <= 8'h00;
      rx_bits_q    <= 3'h0;
      rx_sh_q      <= 8'h00;
      rx_hdr_q     <= 1'b0;
      rx_act_q     <= 1'b0;
    end else if (rx_mode && !rx_prev) begin
      rx_wr_pos_q <= rx_base_q;
      rx_act_q    <= 1'b0;
    end else if (rx_mode && frm_rise) begin
      rx_act_q     <= 1'b1;
      last_start_q <= rx_wr_pos_q;
      rx_hdr_q     <= !implicit_q;
      rx_bits_q    <= 3'h0;
    end else if (rx_act_q && (frm_fall || !rx_mode)) begin
      rx_act_q <= 1'b0;
    end else if (rx_bit_ok) begin
      rx_sh_q   <= rx_byte;
      rx_bits_q <= rx_bits_q + 3'h1;
      if (rx_bits_q == 3'h7) begin
        if (rx_hdr_q) begin
          rx_count_q <= rx_byte;
          rx_hdr_q   <= 1'b0;
        end else begin
          rx_wr_pos_q <= rx_wr_pos_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifts bytes out MSB first, one bit per link clock fall.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q       <= pktbuf_pkg::T_IDLE;
      tx_ptr_q      <= 8'h00;
      tx_left_q     <= 8'h00;
      tx_bit_q      <= 3'h0;
      tx_sh_q       <= 8'h00;
      link_tx_frame <= 1'b0;
      link_tx_data  <= 1'b0;
    end else begin
      unique case (tx_st_q)
        pktbuf_pkg::T_IDLE: begin
          if (tx_start) begin
            tx_ptr_q  <= tx_base_q;
            tx_left_q <= tx_len_q;
            tx_bit_q  <= 3'h0;
            tx_st_q   <= pktbuf_pkg::T_SEND;
          end
        end
        pktbuf_pkg::T_SEND: begin
          if (mode_q != pktbuf_pkg::MODE_TX) begin
            link_tx_frame <= 1'b0;
            link_tx_data  <= 1'b0;
            tx_st_q       <= pktbuf_pkg::T_IDLE;
          end else if (clk_fall && tx_bit_q == 3'h0) begin
            if (tx_left_q == 8'h00) begin
              link_tx_frame <= 1'b0;
              link_tx_data  <= 1'b0;
              tx_st_q       <= pktbuf_pkg::T_END;
            end else begin
              link_tx_frame <= 1'b1;
              link_tx_data  <= mem[tx_ptr_q][7];
              tx_sh_q       <= {mem[tx_ptr_q][6:0], 1'b0};
              tx_ptr_q      <= tx_ptr_q + 8'h01;
              tx_left_q     <= tx_left_q - 8'h01;
              tx_bit_q      <= 3'h1;
            end
          end else if (clk_fall) begin
            link_tx_data <= tx_sh_q[7];
            tx_sh_q      <= {tx_sh_q[6:0], 1'b0};
            tx_bit_q     <= tx_bit_q + 3'h1;
          end
        end
        pktbuf_pkg::T_END: begin
          tx_st_q <= pktbuf_pkg::T_IDLE;
        end
        default: begin
          tx_st_q <= pktbuf_pkg::T_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_sleep_clear: assert property (
    sleep_in |=> clr_busy_q && clr_idx_q == 8'h00)
    else $error("Sleep entry did not start clearing.");

  chk_sleep_deny: assert property (
    (wr_fire && sleep && hit(ap_addr_q, `OFS_DATA)) |=> $stable(ptr_q))
    else $error("Data port access moved pointer in sleep.");

  chk_ptr_inc: assert property (
    (host_dwr || host_drd) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("Access pointer did not advance.");

  chk_tx_return: assert property (
    (tx_end && !mode_wr) |=> mode_q == pktbuf_pkg::MODE_STBY
      && flags_q.tx_done)
    else $error("Transmit end did not return to standby.");

  chk_rx_single: assert property (
    (rx_end && mode_q == pktbuf_pkg::MODE_RXS && !mode_wr)
      |=> mode_q == pktbuf_pkg::MODE_STBY ##1 power.rf_rx == 1'b0)
    else $error("Single receive did not stop after one packet.");

  chk_rx_cont: assert property (
    (rx_end && mode_q == pktbuf_pkg::MODE_RXC && !mode_wr)
      |=> mode_q == pktbuf_pkg::MODE_RXC)
    else $error("Continuous receive left its mode.");

  chk_sel_sleep: assert property (
    $changed(modem_sel_q) |-> $past(mode_q) == pktbuf_pkg::MODE_SLEEP)
    else $error("Modem select changed outside sleep.");

  chk_rx_wrap: assert property (
    (rx_wr_en && rx_wr_pos_q == `BUF_LAST) |=> rx_wr_pos_q == 8'h00)
    else $error("Receive position did not wrap.");

  chk_standby_pwr: assert property (
    (mode_q == pktbuf_pkg::MODE_STBY) |=> power.osc && power.baseband
      && !power.pll_tx && !power.pll_rx && !power.rf_tx && !power.rf_rx)
    else $error("Standby power enables wrong.");

  chk_last_start: assert property (
    (rx_mode && rx_prev && frm_rise) |=> last_start_q == $past(rx_wr_pos_q))
    else $error("Last packet start not recorded.");

  cov_tx_done: cover property (tx_end);
  cov_rx_single: cover property (rx_end && mode_q == pktbuf_pkg::MODE_RXS);
  cov_rx_wrap: cover property (rx_wr_en && rx_wr_pos_q == `BUF_LAST);

endmodule : packet_buffer_mode_control
`default_nettype wire

// ---- test/radio_link_model.sv ----
// Far-side radio model: bit clock, receive frames and transmit capture.
`timescale 1ns/10ps
`default_nettype none
module radio_link_model (
  output logic        link_clk,        // Bit clock, also toggled outside frames.
  output logic        link_rx_frame,   // Receive frame.
  output logic        link_rx_data,    // Receive bit.
  output logic        link_rx_crc_err, // Payload check result.
  input  wire logic   link_tx_frame,   // Transmit frame from the block.
  input  wire logic   link_tx_data,    // Transmit bit from the block.
  output logic [31:0] tx_bits          // Captured transmit bits.
);
  initial begin
    link_clk = 1'b0;
    link_rx_frame = 1'b0;
    link_rx_data = 1'b0;
    link_rx_crc_err = 1'b0;
    tx_bits = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////
  always @(posedge link_clk) begin
    if (link_tx_frame) tx_bits <= {tx_bits[30:0], link_tx_data};
  end
  // Data moves only while the clock is low, so every rise sees a settled bit.
  task automatic tick(input logic b);
    link_rx_data = b;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
  endtask : tick
  // Toggling idle data keeps a stale bit from looking like a valid one.
  // The small offset keeps link edges away from the core clock edges.
  task automatic idle_clocks(input int n);
    #3;
    repeat (n) tick(~link_rx_data);
  endtask : idle_clocks
  task automatic send(input logic [7:0] len, input logic [31:0] d,
                      input logic bad);
    #3;
    link_rx_crc_err = bad;
    link_rx_frame = 1'b1;
    #100;
    for (int i = 7; i >= 0; i--) tick(len[i]);
    for (int i = 31; i >= 32 - 8 * int'(len); i--) tick(d[i]);
    #100 link_rx_frame = 1'b0;
    link_rx_data = ~link_rx_data;
  endtask : send
endmodule : radio_link_model
`default_nettype wire

// ---- test/packet_buffer_mode_control_test.sv ----
// Self-checking bench for the packet buffer and mode control block.
`include "pktbuf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module packet_buffer_mode_control_test;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, carrier_hz, tx_bits;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, link_clk, fr, dat, crc, tx_fr, tx_dat;
  pktbuf_pkg::power_t power;
  int failures = 0, checks = 0;
  logic [31:0] rv;
  logic [23:0] words [3] = '{24'h000001, 24'hFFFFFF, 24'h6C8000};
  always #10 core_clk = ~core_clk;
  packet_buffer_mode_control dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .link_rx_frame(fr), .link_rx_data(dat), .link_rx_crc_err(crc),
    .link_tx_frame(tx_fr), .link_tx_data(tx_dat), .power(power),
    .carrier_hz(carrier_hz));
  radio_link_model link (.link_clk(link_clk), .link_rx_frame(fr),
    .link_rx_data(dat), .link_rx_crc_err(crc), .link_tx_frame(tx_fr),
    .link_tx_data(tx_dat), .tx_bits(tx_bits));
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Address phase, then data phase; each held until hready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    // One bound covers both phases, so a hung address phase still fails.
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      failures++;
      $display("MISMATCH t=%0t bus hang", $time);
      print_verdict();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rc
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rc(`OFS_TX_BASE, 32'h80);
    rc(`OFS_RX_BASE, 32'h00);
    rc(`OFS_OPMODE, 32'h00);
    chk({31'h0, hresp}, 32'h0);
    wr(`OFS_PTR, 32'h10);
    wr(`OFS_DATA, 32'h55);
    rc(`OFS_PTR, 32'h10);
    rc(`OFS_DATA, 32'h00);
    wr(8'h3C, 32'h77);
    rc(8'h3C, 32'h00);
    wr(`OFS_OPMODE, 32'h80);
    rc(`OFS_OPMODE, 32'h80);
    wr(`OFS_OPMODE, 32'h81);
    repeat (270) @(posedge core_clk);
    wr(`OFS_OPMODE, 32'h01);
    rc(`OFS_OPMODE, 32'h81);
    chk({25'h0, power}, 32'h60);
    foreach (words[i]) begin
      wr(`OFS_FREQ, {8'h00, words[i]});
      repeat (3) @(posedge core_clk);
      rv = 32'((64'(words[i]) * `XOSC_HZ) >> `FSTEP_SHIFT);
      chk(carrier_hz, rv);
    end
    // Access pointer wraps from the top byte to zero.
    wr(`OFS_PTR, 32'hFF);
    wr(`OFS_DATA, 32'hDE);
    wr(`OFS_DATA, 32'hAD);
    rc(`OFS_PTR, 32'h01);
    wr(`OFS_PTR, 32'hFF);
    rc(`OFS_DATA, 32'hDE);
    rc(`OFS_DATA, 32'hAD);
    // Mode changes with no self-clearing in between.
    // Power enables follow the mode register one cycle later.
    wr(`OFS_OPMODE, 32'h82);
    repeat (2) @(posedge core_clk);
    chk({29'h0, power.pll_tx, power.rf_tx, power.rf_rx}, 32'h4);
    wr(`OFS_OPMODE, 32'h84);
    repeat (2) @(posedge core_clk);
    chk({29'h0, power.pll_rx, power.rf_tx, power.rf_rx}, 32'h4);
    wr(`OFS_OPMODE, 32'h81);
    rc(`OFS_OPMODE, 32'h81);
    wr(`OFS_PTR, 32'h80);
    wr(`OFS_DATA, 32'hA5);
    wr(`OFS_DATA, 32'h3C);
    wr(`OFS_TX_LEN, 32'h02);
    wr(`OFS_OPMODE, 32'h83);
    link.idle_clocks(24);
    repeat (5) @(posedge core_clk);
    chk({16'h0, tx_bits[15:0]}, 32'hA53C);
    chk({31'h0, tx_fr}, 32'h0);
    rc(`OFS_OPMODE, 32'h81);
    rc(`OFS_FLAGS, 32'h01);
    wr(`OFS_FLAGS, 32'h07);
    // Packet starting below the transmit region runs into it.
    wr(`OFS_RX_BASE, 32'h7E);
    wr(`OFS_OPMODE, 32'h85);
    link.send(8'h03, 32'h11223300, 1'b1);
    repeat (10) @(posedge core_clk);
    rc(`OFS_RX_COUNT, 32'h03);
    rc(`OFS_LAST, 32'h7E);
    rc(`OFS_FLAGS, 32'h06);
    rc(`OFS_OPMODE, 32'h85);
    wr(`OFS_PTR, 32'h7E);
    rc(`OFS_DATA, 32'h11);
    rc(`OFS_DATA, 32'h22);
    rc(`OFS_DATA, 32'h33);
    rc(`OFS_DATA, 32'h3C);
    wr(`OFS_OPMODE, 32'h86);
    link.send(8'h01, 32'h44000000, 1'b0);
    repeat (10) @(posedge core_clk);
    rc(`OFS_OPMODE, 32'h81);
    // Implicit header: every byte is stored, the count is left alone.
    wr(`OFS_CONFIG, 32'h01);
    wr(`OFS_RX_BASE, 32'hFF);
    wr(`OFS_OPMODE, 32'h86);
    link.send(8'h02, 32'h55660000, 1'b0);
    repeat (10) @(posedge core_clk);
    rc(`OFS_RX_COUNT, 32'h01);
    rc(`OFS_LAST, 32'hFF);
    wr(`OFS_PTR, 32'hFF);
    rc(`OFS_DATA, 32'h02);
    rc(`OFS_DATA, 32'h55);
    rc(`OFS_DATA, 32'h66);
    wr(`OFS_OPMODE, 32'h80);
    repeat (300) @(posedge core_clk);
    wr(`OFS_OPMODE, 32'h81);
    repeat (270) @(posedge core_clk);
    wr(`OFS_PTR, 32'h81);
    rc(`OFS_DATA, 32'h00);
    print_verdict();
  end
endmodule : packet_buffer_mode_control_test
`default_nettype wire
